// File: src/hpcpm_core.sv
// Port change flags and downstream port power management
//
// Behaviour
// - External port enable-change set on babble/disconnect/overcurrent
// - Embedded port enable-change set at EOF2 only
// - External connect-change set at EOF2 after change
// - Hub reset sets embedded port connect-change
// - Global mode senses overcurrent during suspend if enabled
// - Individual mode: fault sets indicator, change, powers off
// - Gang sensing grouped, status reported per port
// - Descriptor characteristics encode individual switching and protection
// - Outside global mode, external overcurrent sets both external indicators
// - Shared power on if either external port powered
`timescale 1ns/1ns
module hpcpm_core (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       eofTwo,
  input  wire logic                       hubReset,
  input  wire logic                       hubSuspended,
  input  wire logic [1:0]                 protMode,
  input  wire logic                       suspend_overcurrent_detect_enable,
  input  wire logic                       overcurrent_sense_input,
  input  wire logic [1:0]                 switch_fault_flag_n,
  input  wire logic [hpcpm_pkg::NPORT-1:0] babbleEvt,
  input  wire logic [hpcpm_pkg::NPORT-1:0] enableHwEvt,
  input  wire logic [hpcpm_pkg::NPORT-1:0] connectRaw,
  input  wire logic [hpcpm_pkg::NPORT-1:0] clrEnableChg,
  input  wire logic [hpcpm_pkg::NPORT-1:0] clrConnectChg,
  input  wire logic [hpcpm_pkg::NPORT-1:0] clrOvcChg,
  input  wire logic [hpcpm_pkg::NPORT-1:0] setPortPower,
  input  wire logic [hpcpm_pkg::NPORT-1:0] clrPortPower,
  output logic      [hpcpm_pkg::NPORT-1:0] port_enable_change_flag,
  output logic      [hpcpm_pkg::NPORT-1:0] port_connect_change_flag,
  output logic      [hpcpm_pkg::NPORT-1:0] portOvcIndicator,
  output logic      [hpcpm_pkg::NPORT-1:0] portOvcChange,
  output logic      [hpcpm_pkg::NPORT-1:0] portPowerCtl,
  output logic                            hubOvcIndicator,
  output logic                            hubOvcChange,
  output logic                            gang_power_switch_n,
  output logic      [1:0]                 port_power_switch_n,
  output logic      [7:0]                 hubCharacteristics
);
  localparam int N = hpcpm_pkg::NPORT;

  typedef struct packed {
    logic [N-1:0] enChg;
    logic [N-1:0] conChg;
    logic [N-1:0] conPrev;
    logic [N-1:0] conPend;
    logic [N-1:0] embEnPend;
    logic [N-1:0] ovcInd;
    logic [N-1:0] ovcChg;
    logic [N-1:0] pwr;
    logic         hubOvc;
    logic         hubOvcChg;
    logic         gangOn;
  } hpcpm_st_t;

  hpcpm_st_t st_r;
  hpcpm_st_t st_nxt;

  logic [N-1:0] conSync;
  logic [2:0]   faultSync;
  logic         globalFault;
  logic         extFault;
  logic [N-1:0] ovcDisable;
  logic         ovcEvt;

  hpcpm_sync #(.W(N + 3)) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .din     ({connectRaw, ~switch_fault_flag_n, ~overcurrent_sense_input}),
    .dout    ({conSync, faultSync})
  );

  // Global sense works awake, or suspended when enabled
  assign globalFault = faultSync[0] &
                       (!hubSuspended | suspend_overcurrent_detect_enable);
  // Any external fault, per-port pins grouped into a gang
  assign extFault = (protMode == hpcpm_pkg::MODE_GLOBAL) ? globalFault
                                                         : (|faultSync[2:1]);

  always_comb begin
    st_nxt = st_r;
    ovcDisable = '0;
    ovcEvt = 1'b0;
    // Hub-level indicators in global mode
    if (protMode == hpcpm_pkg::MODE_GLOBAL) begin
      st_nxt.ovcInd = '0;
      st_nxt.ovcChg = '0;
      if (globalFault != st_r.hubOvc) begin
        st_nxt.hubOvc = globalFault;
        st_nxt.hubOvcChg = 1'b1;
      end
    end else begin
      if (extFault != st_r.ovcInd[hpcpm_pkg::EXT_A]) begin
        ovcEvt = 1'b1;
        st_nxt.ovcInd[hpcpm_pkg::EXT_A] = extFault;
        st_nxt.ovcInd[hpcpm_pkg::EXT_B] = extFault;
        st_nxt.ovcChg[hpcpm_pkg::EXT_A] = 1'b1;
        st_nxt.ovcChg[hpcpm_pkg::EXT_B] = 1'b1;
      end
      st_nxt.ovcInd[hpcpm_pkg::EMB] = 1'b0;
      st_nxt.ovcChg[hpcpm_pkg::EMB] = 1'b0;
    end
    if (extFault) begin
      ovcDisable[hpcpm_pkg::EXT_A] = 1'b1;
      ovcDisable[hpcpm_pkg::EXT_B] = 1'b1;
    end
    for (int i = 0; i < N; i++) begin
      // Port power control
      if (setPortPower[i]) begin
        st_nxt.pwr[i] = 1'b1;
      end
      if (clrPortPower[i] | ovcDisable[i]) begin
        st_nxt.pwr[i] = 1'b0;
      end
      if (i == hpcpm_pkg::EMB) begin
        st_nxt.pwr[i] = 1'b1;
        // Embedded event held until EOF2
        if (enableHwEvt[i]) begin
          st_nxt.embEnPend[i] = 1'b1;
        end
        if (eofTwo && (st_r.embEnPend[i] | enableHwEvt[i])) begin
          st_nxt.embEnPend[i] = 1'b0;
        end
      end else begin
        st_nxt.embEnPend[i] = 1'b0;
        // Connect change pending until EOF2
        if (conSync[i] != st_r.conPrev[i]) begin
          st_nxt.conPend[i] = 1'b1;
        end
        st_nxt.conPrev[i] = conSync[i];
        if (eofTwo) begin
          st_nxt.conPend[i] = 1'b0;
        end
      end
      // Clears first, then sets win
      if (clrEnableChg[i]) begin
        st_nxt.enChg[i] = 1'b0;
      end
      if (clrConnectChg[i]) begin
        st_nxt.conChg[i] = 1'b0;
      end
      if (clrOvcChg[i]) begin
        st_nxt.ovcChg[i] = 1'b0;
      end
      // A fresh indicator change beats a clear in the same cycle
      if (ovcEvt && (i != hpcpm_pkg::EMB)) begin
        st_nxt.ovcChg[i] = 1'b1;
      end
      if (i == hpcpm_pkg::EMB) begin
        if (eofTwo && (st_r.embEnPend[i] | enableHwEvt[i])) begin
          st_nxt.enChg[i] = 1'b1;
        end
        if (hubReset) begin
          st_nxt.conChg[i] = 1'b1;
        end
      end else begin
        if (babbleEvt[i] | (st_r.conPrev[i] & !conSync[i]) | (ovcDisable[i] & st_r.pwr[i])) begin
          st_nxt.enChg[i] = 1'b1;
        end
        if (eofTwo && (st_r.conPend[i] | (conSync[i] != st_r.conPrev[i]))) begin
          st_nxt.conChg[i] = 1'b1;
        end
      end
    end
    st_nxt.gangOn = st_nxt.pwr[hpcpm_pkg::EXT_A] | st_nxt.pwr[hpcpm_pkg::EXT_B];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign port_enable_change_flag = st_r.enChg;
  assign port_connect_change_flag = st_r.conChg;
  assign portOvcIndicator = st_r.ovcInd;
  assign portOvcChange = st_r.ovcChg;
  assign portPowerCtl = st_r.pwr;
  assign hubOvcIndicator = st_r.hubOvc;
  assign hubOvcChange = st_r.hubOvcChg;
  assign gang_power_switch_n = !st_r.gangOn;
  assign port_power_switch_n = ~st_r.pwr[N-1:1];

  always_comb begin
    hubCharacteristics = hpcpm_pkg::HUB_CHAR_RST;
    hubCharacteristics[hpcpm_pkg::CHAR_PWR_LSB +: 2] = hpcpm_pkg::PWR_SW_INDIV;
    hubCharacteristics[hpcpm_pkg::CHAR_OVC_LSB +: 2] = hpcpm_pkg::OVC_PROT_INDIV;
  end

  property p_emb_en_eof;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(st_r.enChg[hpcpm_pkg::EMB]) |-> $past(eofTwo);
  endproperty
  a_emb_en_eof: assert property (p_emb_en_eof) else $error("embedded enable change off EOF2");

  property p_babble;
    @(posedge ref_clk) disable iff (!rst_b)
    babbleEvt[hpcpm_pkg::EXT_A] |=> st_r.enChg[hpcpm_pkg::EXT_A];
  endproperty
  a_babble: assert property (p_babble) else $error("babble did not set enable change");

  property p_con_eof;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(st_r.conChg[hpcpm_pkg::EXT_B]) |-> $past(eofTwo);
  endproperty
  a_con_eof: assert property (p_con_eof) else $error("connect change off EOF2");

  property p_reset_con;
    @(posedge ref_clk) disable iff (!rst_b)
    hubReset |=> st_r.conChg[hpcpm_pkg::EMB];
  endproperty
  a_reset_con: assert property (p_reset_con) else $error("hub reset missed connect change");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_b)
    (st_r.enChg[hpcpm_pkg::EXT_A] && !clrEnableChg[hpcpm_pkg::EXT_A])
      |=> st_r.enChg[hpcpm_pkg::EXT_A];
  endproperty
  a_sticky: assert property (p_sticky) else $error("enable change lost");

  property p_both_ovc;
    @(posedge ref_clk) disable iff (!rst_b)
    portOvcIndicator[hpcpm_pkg::EXT_A] == portOvcIndicator[hpcpm_pkg::EXT_B];
  endproperty
  a_both_ovc: assert property (p_both_ovc) else $error("external indicators differ");

  property p_gang;
    @(posedge ref_clk) disable iff (!rst_b)
    (setPortPower[hpcpm_pkg::EXT_B] && !clrPortPower[hpcpm_pkg::EXT_B] && !extFault)
      |=> !gang_power_switch_n;
  endproperty
  a_gang: assert property (p_gang) else $error("gang switch wrong");

  property p_ovc_off;
    @(posedge ref_clk) disable iff (!rst_b)
    extFault |=> !st_r.pwr[hpcpm_pkg::EXT_A] && !st_r.pwr[hpcpm_pkg::EXT_B];
  endproperty
  a_ovc_off: assert property (p_ovc_off) else $error("power not cut on overcurrent");

  property p_global_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    (protMode == hpcpm_pkg::MODE_GLOBAL) |=> (st_r.ovcInd == '0);
  endproperty
  a_global_zero: assert property (p_global_zero) else $error("port ovc set in global mode");

  c_emb_en: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(st_r.enChg[0]));
  c_con: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(st_r.conChg[1]));
  c_ovc: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(st_r.ovcInd[2]));
  c_gang: cover property (@(posedge ref_clk) disable iff (!rst_b) $fell(gang_power_switch_n));
endmodule

// File: src/hpcpm_pkg.sv
// Package with constants for the hub port change and power management block
package hpcpm_pkg;
  localparam int NPORT = 3;              // Port 1 embedded, ports 2 and 3 external
  localparam int EMB = 0;                // Index of embedded function port
  localparam int EXT_A = 1;              // Index of first external port
  localparam int EXT_B = 2;              // Index of second external port
  localparam logic [1:0] PWR_SW_INDIV = 2'h1;
  localparam logic [1:0] OVC_PROT_INDIV = 2'h1;
  localparam int CHAR_PWR_LSB = 0;
  localparam int CHAR_OVC_LSB = 3;
  localparam logic [7:0] HUB_CHAR_RST = 8'h00;
  localparam logic [1:0] MODE_GLOBAL = 2'h0;
  localparam logic [1:0] MODE_INDIV = 2'h1;
  localparam logic [1:0] MODE_MGANG = 2'h2;
endpackage

// File: src/hpcpm_sync.sv
// Two-stage synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
module hpcpm_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hpcpm_sync_t;

  hpcpm_sync_t st_r;
  hpcpm_sync_t st_nxt;

  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;
endmodule

// File: bench/hpcpm_switch_model.sv
// Behavioural model of the external power switches and their fault flags
`timescale 1ns/1ns
module hpcpm_switch_model (
  input  wire logic       gang_power_switch_n,
  input  wire logic [1:0] port_power_switch_n,
  input  wire logic       gangFault,
  input  wire logic [1:0] portFault,
  output logic            overcurrent_sense_input,
  output logic [1:0]      switch_fault_flag_n
);
  // Shared switch flags a fault only while powered; the pull-up idles high
  assign overcurrent_sense_input = ~(gangFault & ~gang_power_switch_n);
  // One switch per port, each flag wired to its own port
  assign switch_fault_flag_n = ~(portFault & ~port_power_switch_n);
endmodule

// File: bench/tb.sv
// Self-checking testbench for the hub port change and power management block
`timescale 1ns/1ns
`define CHK(a, b, m) begin checksDone++; if ((a) !== (b)) begin failCount++; \
  $display("unexpected %0t %s", $time, m); end end
module tb;
  logic       ref_clk, rst_b, eofTwo, hubReset, hubSuspended, suspEn, gangFault;
  logic [1:0] protMode, portFault;
  logic [2:0] babbleEvt, enableHwEvt, connectRaw, clrEnableChg, clrConnectChg;
  logic [2:0] clrOvcChg, setPortPower, clrPortPower;
  logic [2:0] enChg, conChg, ovcInd, ovcChg, pwrCtl;
  logic       ovcSense, hubOvcInd, hubOvcChg, gangSwN;
  logic [1:0] faultFlagN, portSwN;
  logic [7:0] hubChar;
  int         failCount = 0;
  int         checksDone = 0;

  hpcpm_core u_hpcpm_core (
    .ref_clk(ref_clk), .rst_b(rst_b), .eofTwo(eofTwo), .hubReset(hubReset),
    .hubSuspended(hubSuspended), .protMode(protMode),
    .suspend_overcurrent_detect_enable(suspEn), .overcurrent_sense_input(ovcSense),
    .switch_fault_flag_n(faultFlagN), .babbleEvt(babbleEvt), .enableHwEvt(enableHwEvt),
    .connectRaw(connectRaw), .clrEnableChg(clrEnableChg), .clrConnectChg(clrConnectChg),
    .clrOvcChg(clrOvcChg), .setPortPower(setPortPower), .clrPortPower(clrPortPower),
    .port_enable_change_flag(enChg), .port_connect_change_flag(conChg),
    .portOvcIndicator(ovcInd), .portOvcChange(ovcChg), .portPowerCtl(pwrCtl),
    .hubOvcIndicator(hubOvcInd), .hubOvcChange(hubOvcChg), .gang_power_switch_n(gangSwN),
    .port_power_switch_n(portSwN), .hubCharacteristics(hubChar));

  hpcpm_switch_model u_hpcpm_switch_model (
    .gang_power_switch_n(gangSwN), .port_power_switch_n(portSwN), .gangFault(gangFault),
    .portFault(portFault), .overcurrent_sense_input(ovcSense),
    .switch_fault_flag_n(faultFlagN));

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic finishTest();
    if (failCount == 0 && checksDone > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic powerStep(input logic [2:0] s, c, ePwr, input logic eGang,
                           input logic [1:0] eSw);
    @(posedge ref_clk); setPortPower <= s; clrPortPower <= c;
    @(posedge ref_clk); setPortPower <= 3'h0; clrPortPower <= 3'h0;
    #1;
    `CHK(pwrCtl, ePwr, "power bits")
    `CHK(gangSwN, eGang, "shared switch")
    `CHK(portSwN, eSw, "port switches")
  endtask

  task automatic testReset();
    settle(1);
    `CHK({enChg, conChg, ovcChg}, 9'h000, "flags after reset")
    `CHK(pwrCtl, 3'h1, "power after reset")
    `CHK(hubChar, 8'h09, "characteristics")
  endtask

  task automatic testBabble();
    @(posedge ref_clk); babbleEvt <= 3'h4;
    @(posedge ref_clk); babbleEvt <= 3'h0;
    settle(3);
    `CHK(enChg, 3'h4, "babble change held")
    @(posedge ref_clk); clrEnableChg <= 3'h4;
    @(posedge ref_clk); clrEnableChg <= 3'h0;
    #1 `CHK(enChg, 3'h0, "enable change clear")
  endtask

  task automatic testEmbedded();
    @(posedge ref_clk); enableHwEvt <= 3'h1;
    @(posedge ref_clk); enableHwEvt <= 3'h0;
    settle(2);
    `CHK(enChg, 3'h0, "embedded before eof")
    @(posedge ref_clk); eofTwo <= 1'b1;
    @(posedge ref_clk); eofTwo <= 1'b0;
    #1 `CHK(enChg, 3'h1, "embedded at eof")
    @(posedge ref_clk); clrEnableChg <= 3'h1;
    @(posedge ref_clk); clrEnableChg <= 3'h0;
  endtask

  task automatic testConnect();
    @(posedge ref_clk); connectRaw <= 3'h3;
    settle(5);
    `CHK(conChg, 3'h0, "connect before eof")
    @(posedge ref_clk); eofTwo <= 1'b1;
    @(posedge ref_clk); eofTwo <= 1'b0;
    #1 `CHK(conChg, 3'h2, "connect at eof")
    @(posedge ref_clk); clrConnectChg <= 3'h2; hubReset <= 1'b1;
    @(posedge ref_clk); clrConnectChg <= 3'h0; hubReset <= 1'b0;
    #1 `CHK(conChg, 3'h1, "clear and hub reset")
    @(posedge ref_clk); connectRaw <= 3'h0;
    settle(3);
    `CHK(enChg, 3'h2, "disconnect enable change")
    `CHK(conChg, 3'h1, "disconnect waits for eof")
    @(posedge ref_clk); clrEnableChg <= 3'h2;
    @(posedge ref_clk); clrEnableChg <= 3'h0;
  endtask

  task automatic testFault();
    powerStep(3'h6, 3'h0, 3'h7, 1'b0, 2'h0);
    @(posedge ref_clk); portFault <= 2'h1;
    for (int i = 0; i < 8 && ovcChg[1] !== 1'b1; i++) settle(1);
    `CHK({ovcInd[2:1], ovcChg[2:1]}, 4'hF, "both ports flagged")
    `CHK({pwrCtl, gangSwN}, 4'h3, "power cut on fault")
    `CHK(enChg[1], 1'b1, "overcurrent enable change")
    @(posedge ref_clk); portFault <= 2'h0; clrOvcChg <= 3'h6; clrEnableChg <= 3'h6;
    @(posedge ref_clk); clrOvcChg <= 3'h0; clrEnableChg <= 3'h0;
    #1 `CHK(ovcChg, 3'h0, "overcurrent change clear")
  endtask

  task automatic testGlobal();
    @(posedge ref_clk); protMode <= 2'h0; hubSuspended <= 1'b1; suspEn <= 1'b0;
    powerStep(3'h2, 3'h0, 3'h3, 1'b0, 2'h2);
    @(posedge ref_clk); gangFault <= 1'b1;
    settle(5);
    `CHK({hubOvcChg, gangSwN}, 2'h0, "suspended sense masked")
    @(posedge ref_clk); suspEn <= 1'b1;
    for (int i = 0; i < 8 && hubOvcChg !== 1'b1; i++) settle(1);
    `CHK({hubOvcInd, hubOvcChg}, 2'h3, "suspended global sense")
    `CHK({ovcInd, ovcChg}, 6'h00, "port bits stay zero")
    `CHK(gangSwN, 1'b1, "global cut")
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    #20000;
    failCount++;
    finishTest();
  end

  initial begin
    {rst_b, eofTwo, hubReset, hubSuspended, suspEn, gangFault, portFault} = '0;
    {babbleEvt, enableHwEvt, connectRaw, clrEnableChg, clrConnectChg} = '0;
    {clrOvcChg, setPortPower, clrPortPower} = '0;
    protMode = 2'h1;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    testReset();
    testBabble();
    testEmbedded();
    testConnect();
    powerStep(3'h2, 3'h0, 3'h3, 1'b0, 2'h2);
    powerStep(3'h4, 3'h0, 3'h7, 1'b0, 2'h0);
    powerStep(3'h0, 3'h2, 3'h5, 1'b0, 2'h1);
    powerStep(3'h0, 3'h4, 3'h1, 1'b1, 2'h3);
    testFault();
    testGlobal();
    finishTest();
  end
endmodule
